//--- core/sbc_mode_pkg.sv
// shared constants and types for the mode and watchdog command decoder
package sbc_mode_pkg;

    // ------------------------------------------------------------------
    // frame and register addressing
    // ------------------------------------------------------------------
    localparam int CMD_W = 16;
    localparam int BITCNT_W = 5;
    localparam logic [BITCNT_W-1:0] FRAME_BITS = 5'h10;
    localparam logic [BITCNT_W-1:0] BITCNT_MAX = 5'h1F;
    localparam logic [4:0] REG_WATCHDOG_REFRESH = 5'h0D;
    localparam logic [4:0] REG_OPERATING_MODE_SELECT = 5'h0E;
    // first byte = {b15,b14, register, b8}
    localparam logic [1:0] PFX_WRITE = 2'h1;
    localparam logic [1:0] PFX_GLOBAL_RND = 2'h0;
    localparam logic [1:0] PFX_GLOBAL_STAT = 2'h3;
    localparam logic [7:0] BYTE_WD_WRITE = {PFX_WRITE, REG_WATCHDOG_REFRESH, 1'b0};
    localparam logic [7:0] BYTE_RETURN = {PFX_WRITE, REG_WATCHDOG_REFRESH, 1'b1};
    localparam logic [7:0] BYTE_MODE_WRITE = {PFX_WRITE, REG_OPERATING_MODE_SELECT, 1'b0};
    localparam logic [7:0] BYTE_GLOBAL_RND = {PFX_GLOBAL_RND, REG_OPERATING_MODE_SELECT, 1'b1};
    localparam logic [7:0] BYTE_GLOBAL_STAT = {PFX_GLOBAL_STAT, REG_OPERATING_MODE_SELECT, 1'b1};
    localparam logic [15:0] CMD_WD_REFRESH = {BYTE_WD_WRITE, 8'h00};

    // ------------------------------------------------------------------
    // mode field layout and encodings
    // ------------------------------------------------------------------
    localparam int SEL_MSB = 7;
    localparam int SEL_LSB = 3;
    localparam int RND_MSB = 2;
    localparam logic [4:0] MODE_INIT = 5'h00;
    localparam logic [4:0] MODE_FLASH = 5'h01;
    localparam logic [4:0] MODE_NORMAL_REQ = 5'h02;
    localparam logic [4:0] MODE_NORMAL = 5'h03;
    localparam logic [2:0] LP_OFF_GROUP = 3'h3;
    localparam int LP_ON_BIT = 4;
    localparam logic [1:0] RET_TO_RESET = 2'h0;
    localparam logic [1:0] RET_TO_FLASH = 2'h2;
    localparam logic [7:0] FIX_STATUS = 8'h00;
    localparam logic [7:0] LFSR_SEED = 8'hA5;

    // ------------------------------------------------------------------
    // carriers
    // ------------------------------------------------------------------
    typedef struct packed {
        logic sclk;
        logic cs_n;
        logic mosi;
    } spi_pins_s;

    typedef struct packed {
        logic low_power_regulator_off;
        logic low_power_regulator_on;
        logic timed_forced_wakeup;
        logic cyclic_sense;
        logic cyclic_int;
        logic lp_watchdog;
    } lp_cfg_s;

    typedef enum logic [0:0] {
        FR_IDLE = 1'b0,
        FR_SHIFT = 1'b1
    } frame_e;

endpackage : sbc_mode_pkg

//--- core/sbc_pin_sync.sv
// two-stage synchroniser with edge detection for a group of pins
module sbc_pin_sync #(
    parameter int W = 3,
    // level each pin rests at, so reset shows no false edge
    parameter logic [W-1:0] IDLE = '0
) (
    // clock and reset
    input wire logic i_sys_clk,
    input wire logic i_rst,
    // pins from outside the clock domain
    input wire logic [W-1:0] i_async,
    // synchronised level and one-cycle edges
    output logic [W-1:0] o_level,
    output logic [W-1:0] o_rise,
    output logic [W-1:0] o_fall
);
    import sbc_mode_pkg::*;

    typedef struct packed {
        logic [W-1:0] meta;
        logic [W-1:0] sync;
        logic [W-1:0] last;
    } sync_s;

    sync_s st;
    sync_s next_st;

    // ------------------------------------------------------------------
    // stages: meta feeds only sync, edges look at sync and last
    // ------------------------------------------------------------------
    always_comb begin
        next_st.meta = i_async;
        next_st.sync = st.meta;
        next_st.last = st.sync;
    end

    always_ff @(posedge i_sys_clk) begin
        if (i_rst) begin
            st <= '{meta: IDLE, sync: IDLE, last: IDLE};
        end else begin
            st <= next_st;
        end
    end

    // outputs from flops only
    assign o_level = st.sync;
    assign o_rise = st.sync & ~st.last;
    assign o_fall = ~st.sync & st.last;

endmodule : sbc_pin_sync

//--- core/sbc_mode_cmd.sv
// serial command decoder for watchdog refresh, mode changes and global status reads
module sbc_mode_cmd (
    // clock and reset
    input wire logic i_sys_clk,
    input wire logic i_rst,
    // serial pins to and from the controller
    input wire sbc_mode_pkg::spi_pins_s i_spi,
    output logic o_spi_miso,
    output logic o_spi_miso_oe,
    // device side inputs
    input wire logic i_rnd_guard_sel,
    input wire logic i_wake_pending,
    input wire logic i_safe_set,
    input wire logic i_debug_strap,
    // mode state and controls
    output logic [4:0] o_mode,
    output sbc_mode_pkg::lp_cfg_s o_lp_cfg,
    output logic o_debug,
    output logic o_safe_on,
    output logic o_wd_refresh,
    output logic o_reset_req,
    output logic o_wakeup
);
    import sbc_mode_pkg::*;

    typedef struct packed {
        frame_e fr;
        logic [BITCNT_W-1:0] bitcnt;
        logic [CMD_W-1:0] rx;
        logic [CMD_W-1:0] tx;
        logic [7:0] resp;
        logic [4:0] mode;
        lp_cfg_s lp;
        logic debug;
        logic safe;
        logic strap_done;
        logic guard_sel;
        logic [2:0] rnd_read;
        logic [7:0] lfsr;
        logic wd_pulse;
        logic reset_pulse;
        logic wake_pulse;
    } core_s;

    core_s st;
    core_s next_st;

    logic [2:0] pin_level;
    logic [2:0] pin_rise;
    logic [2:0] pin_fall;
    // rest levels: clock low, select high, data low
    localparam logic [2:0] PIN_IDLE = 3'h2;

    // ------------------------------------------------------------------
    // pin synchronisation, index 2 clock, 1 select, 0 data
    // ------------------------------------------------------------------
    sbc_pin_sync #(
        .W(3),
        .IDLE(PIN_IDLE)
    ) u_sync (
        .i_sys_clk(i_sys_clk),
        .i_rst(i_rst),
        .i_async({i_spi.sclk, i_spi.cs_n, i_spi.mosi}),
        .o_level(pin_level),
        .o_rise(pin_rise),
        .o_fall(pin_fall)
    );

    // regulator-off group or regulator-on group
    function automatic logic is_lp(input logic [4:0] code);
        is_lp = code[LP_ON_BIT] || (code[4:2] == LP_OFF_GROUP);
    endfunction : is_lp

    // decode a low power selection into its enables
    function automatic lp_cfg_s lp_decode(input logic [4:0] sel);
        lp_cfg_s c;
        c = '0;
        if (sel[LP_ON_BIT]) begin
            c.low_power_regulator_on = 1'b1;
            c.timed_forced_wakeup = sel[3];
            c.cyclic_sense = sel[2];
            c.cyclic_int = sel[1];
            c.lp_watchdog = sel[0];
        end else begin
            c.low_power_regulator_off = 1'b1;
            c.timed_forced_wakeup = sel[1];
            c.cyclic_sense = sel[0];
        end
        lp_decode = c;
    endfunction : lp_decode

    logic [CMD_W-1:0] cmd;
    logic [4:0] sel;
    logic [2:0] rnd_in;
    logic code_ok;

    // ------------------------------------------------------------------
    // field taps of the received word
    // ------------------------------------------------------------------
    assign cmd = st.rx;
    assign sel = cmd[SEL_MSB:SEL_LSB];
    assign rnd_in = cmd[RND_MSB:0];
    // a guarded request must carry the last code read, inverted
    assign code_ok = !st.guard_sel || (rnd_in == ~st.rnd_read);

    // ------------------------------------------------------------------
    // next state
    // ------------------------------------------------------------------
    always_comb begin
        next_st = st;
        next_st.wd_pulse = 1'b0;
        next_st.reset_pulse = 1'b0;
        next_st.wake_pulse = 1'b0;
        // free-running code source, sampled at each code read
        // fixed seed keeps runs repeatable; a guard, not a secret
        next_st.lfsr = {st.lfsr[6:0], st.lfsr[7] ^ st.lfsr[5] ^ st.lfsr[4] ^ st.lfsr[3]};

        // debug strap taken once, on the first edge after reset
        // later strap changes are ignored until the next reset
        if (!st.strap_done) begin
            next_st.debug = i_debug_strap;
            next_st.strap_done = 1'b1;
        end

        // guard choice follows its config bit only in INIT, then freezes
        if (st.mode == MODE_INIT) begin
            next_st.guard_sel = i_rnd_guard_sel;
        end

        // frame tracking: open on select fall, shift until select rises
        case (st.fr)
            FR_IDLE: begin
                if (pin_fall[1]) begin
                    // load fixed status and the previous answer
                    next_st.fr = FR_SHIFT;
                    next_st.bitcnt = '0;
                    next_st.tx = {FIX_STATUS, st.resp};
                end
            end
            FR_SHIFT: begin
                // sample on rising clock, shift out on falling
                if (pin_rise[2]) begin
                    next_st.rx = {st.rx[CMD_W-2:0], pin_level[0]};
                    // saturate so an overlong frame never wraps back to sixteen
                    if (st.bitcnt != BITCNT_MAX) begin
                        next_st.bitcnt = st.bitcnt + 5'h01;
                    end
                end
                if (pin_fall[2]) begin
                    next_st.tx = {st.tx[CMD_W-2:0], 1'b0};
                end
                if (pin_rise[1]) begin
                    next_st.fr = FR_IDLE;
                end
            end
            default: begin
                next_st.fr = FR_IDLE;
            end
        endcase

        // execute on frame end, only a frame of exactly sixteen bits
        if (pin_rise[1] && st.fr == FR_SHIFT && st.bitcnt == FRAME_BITS) begin
            case (cmd[15:8])
                BYTE_WD_WRITE: begin
                    // any nonzero low byte is not a refresh; drop it
                    if (cmd == CMD_WD_REFRESH) begin
                        next_st.wd_pulse = 1'b1;
                        if (st.mode == MODE_INIT || st.mode == MODE_NORMAL_REQ) begin
                            next_st.mode = MODE_NORMAL;
                        end
                    end
                end
                BYTE_RETURN: begin
                    // low six bits must be clear, anything else is dropped
                    if (cmd[5:0] == 6'h00) begin
                        if (cmd[7:6] == RET_TO_RESET) begin
                            next_st.mode = MODE_INIT;
                            next_st.lp = '0;
                            next_st.reset_pulse = 1'b1;
                        end else if (cmd[7:6] == RET_TO_FLASH) begin
                            next_st.mode = MODE_FLASH;
                            next_st.lp = '0;
                        end
                    end
                end
                BYTE_MODE_WRITE: begin
                    // low power entry is taken from Normal only, else dropped silently
                    if (sel == MODE_NORMAL_REQ && st.lp.low_power_regulator_on) begin
                        // serial wake from regulator-on low power
                        next_st.mode = MODE_NORMAL_REQ;
                        next_st.lp = '0;
                        next_st.wake_pulse = 1'b1;
                    end else if (is_lp(sel) && st.mode == MODE_NORMAL && code_ok) begin
                        // unguarded requests ignore the low bits, so 0x5C60 enters
                        next_st.mode = sel;
                        next_st.lp = lp_decode(sel);
                    end
                end
                BYTE_GLOBAL_RND: begin
                    if (cmd[6:0] == 7'h00) begin
                        if (cmd[7]) begin
                            next_st.safe = 1'b0;
                        end else begin
                            next_st.debug = 1'b0;
                        end
                        next_st.resp = {st.mode, st.lfsr[2:0]};
                        next_st.rnd_read = st.lfsr[2:0];
                    end
                end
                BYTE_GLOBAL_STAT: begin
                    if (cmd[6:0] == 7'h00) begin
                        if (cmd[7]) begin
                            next_st.safe = 1'b0;
                        end else begin
                            next_st.debug = 1'b0;
                        end
                        // answer shows state before this command's own effect
                        next_st.resp = {st.mode, 1'b0, st.safe, st.debug};
                    end
                end
                default: begin
                    // other registers belong to other blocks
                end
            endcase
        end

        // a flag left pending wakes the device right after low power entry
        // placed after the decode so it outranks a command in the same cycle
        if (is_lp(st.mode) && i_wake_pending) begin
            next_st.mode = MODE_NORMAL_REQ;
            next_st.lp = '0;
            next_st.wake_pulse = 1'b1;
        end

        // hardware activation of the safe driver wins over a clear
        if (i_safe_set) begin
            next_st.safe = 1'b1;
        end
    end

    // ------------------------------------------------------------------
    // state register
    // ------------------------------------------------------------------
    // whole state clears together, so no half frame survives reset
    always_ff @(posedge i_sys_clk) begin
        if (i_rst) begin
            st <= '{
                fr: FR_IDLE,
                bitcnt: '0,
                rx: '0,
                tx: '0,
                resp: '0,
                mode: MODE_INIT,
                lp: '0,
                debug: 1'b0,
                safe: 1'b0,
                strap_done: 1'b0,
                guard_sel: 1'b0,
                rnd_read: '0,
                lfsr: LFSR_SEED,
                wd_pulse: 1'b0,
                reset_pulse: 1'b0,
                wake_pulse: 1'b0
            };
        end else begin
            st <= next_st;
        end
    end

    // ------------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------------
    // data line driven only while a frame is open
    assign o_spi_miso = st.tx[CMD_W-1];
    assign o_spi_miso_oe = (st.fr == FR_SHIFT);
    assign o_mode = st.mode;
    assign o_lp_cfg = st.lp;
    assign o_debug = st.debug;
    assign o_safe_on = st.safe;
    // pulses stand one cycle; consumers must register them
    assign o_wd_refresh = st.wd_pulse;
    assign o_reset_req = st.reset_pulse;
    assign o_wakeup = st.wake_pulse;

endmodule : sbc_mode_cmd

//--- verif/sbc_mode_cmd_assertions.sv
// concurrent checks on the ports of the mode command decoder
module sbc_mode_cmd_assertions (
    // clock and reset
    input wire logic i_sys_clk,
    input wire logic i_rst,
    // inputs
    input wire sbc_mode_pkg::spi_pins_s i_spi,
    input wire logic i_wake_pending,
    input wire logic i_safe_set,
    // outputs
    input wire logic o_spi_miso_oe,
    input wire logic [4:0] o_mode,
    input wire sbc_mode_pkg::lp_cfg_s o_lp_cfg,
    input wire logic o_debug,
    input wire logic o_safe_on,
    input wire logic o_wd_refresh,
    input wire logic o_reset_req,
    input wire logic o_wakeup
);
    timeunit 1ns;
    timeprecision 1ps;
    import sbc_mode_pkg::*;
    default clocking cb @(posedge i_sys_clk); endclocking
    default disable iff (i_rst);
    // any low power mode, regulator on or off
    sequence in_low_power;
        o_mode[4] || o_mode[4:2] == 3'b011;
    endsequence
    a_reset_init: assert property ($fell(i_rst) |-> o_mode == MODE_INIT && !o_safe_on)
        else $error("mode not cleared by reset");
    a_refresh_pulse: assert property (o_wd_refresh |=> !o_wd_refresh)
        else $error("refresh pulse too long");
    a_wake_lands: assert property (in_low_power ##0 i_wake_pending |=> o_mode == MODE_NORMAL_REQ && o_wakeup)
        else $error("pending wake not taken");
    a_wakeup_normreq: assert property (o_wakeup |-> o_mode == MODE_NORMAL_REQ)
        else $error("wake pulse outside normal request");
    a_lp_on_cfg: assert property (o_mode[4] |-> o_lp_cfg == {2'b01, o_mode[3:0]})
        else $error("regulator on config wrong");
    a_lp_off_cfg: assert property (o_mode[4:2] == 3'b011 |-> o_lp_cfg == {2'b10, o_mode[1:0], 2'b00})
        else $error("regulator off config wrong");
    a_safe_wins: assert property (i_safe_set |=> o_safe_on)
        else $error("safe driver not set");
    a_return_init: assert property (o_reset_req |-> o_mode == MODE_INIT)
        else $error("reset pulse without init mode");
    // the strap lands one edge after release, so look two edges back
    a_debug_no_rise: assert property (!$past(i_rst, 2) |-> !$rose(o_debug))
        else $error("debug set outside reset");
    a_oe_frame: assert property ($fell(i_spi.cs_n) |-> ##[1:5] o_spi_miso_oe)
        else $error("answer driver late");
endmodule : sbc_mode_cmd_assertions

bind sbc_mode_cmd sbc_mode_cmd_assertions i_sbc_mode_cmd_assertions (
    .i_sys_clk(i_sys_clk),
    .i_rst(i_rst),
    .i_spi(i_spi),
    .i_wake_pending(i_wake_pending),
    .i_safe_set(i_safe_set),
    .o_spi_miso_oe(o_spi_miso_oe),
    .o_mode(o_mode),
    .o_lp_cfg(o_lp_cfg),
    .o_debug(o_debug),
    .o_safe_on(o_safe_on),
    .o_wd_refresh(o_wd_refresh),
    .o_reset_req(o_reset_req),
    .o_wakeup(o_wakeup)
);

//--- verif/sbc_spi_master.sv
// controller model driving serial command frames
module sbc_spi_master (
    // pacing clock
    input wire logic i_sys_clk,
    // serial pins
    output sbc_mode_pkg::spi_pins_s o_spi,
    input wire logic i_spi_miso
);
    timeunit 1ns;
    timeprecision 1ps;
    import sbc_mode_pkg::*;
    initial o_spi = '{sclk: 1'b0, cs_n: 1'b1, mosi: 1'b0};
    // half of the 160 ns link period
    task automatic half();
        repeat (4) @(negedge i_sys_clk);
    endtask : half
    // one frame, msb first; link clock stands still between frames
    task automatic xfer(input logic [15:0] tx, output logic [15:0] rx);
        o_spi.cs_n = 1'b0;
        for (int b = 15; b >= 0; b--) begin
            o_spi.mosi = tx[b];
            half();
            rx[b] = i_spi_miso;
            o_spi.sclk = 1'b1;
            half();
            o_spi.sclk = 1'b0;
        end
        half();
        o_spi.cs_n = 1'b1;
        // released data line must not keep its last value
        o_spi.mosi = ~o_spi.mosi;
        repeat (10) @(negedge i_sys_clk);
    endtask : xfer
endmodule : sbc_spi_master

//--- verif/testbench.sv
// self-checking bench for the mode and watchdog command decoder
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    import sbc_mode_pkg::*;
    logic i_sys_clk = 1'b0;
    logic i_rst = 1'b1;
    logic i_rnd_guard_sel = 1'b0, i_wake_pending = 1'b0, i_safe_set = 1'b0, i_debug_strap = 1'b1;
    spi_pins_s spi;
    logic o_spi_miso, o_spi_miso_oe, o_debug, o_safe_on, o_wd_refresh, o_reset_req, o_wakeup;
    logic [4:0] o_mode;
    lp_cfg_s o_lp_cfg;
    logic [15:0] rx;
    logic [2:0] code;
    logic [15:0] clr [4] = '{16'hE100, 16'hE380, 16'hE700, 16'hE180};
    int mismatches = 0, n_checks = 0, n_wake = 0, n_wd = 0, n_rst = 0;
    // undriven answer line reads as pulled high
    wire miso_line = o_spi_miso_oe ? o_spi_miso : 1'b1;

`define CHECK(name, exp, got) begin n_checks++; if ((got) !== (exp)) begin mismatches++; \
    $display("wrong value %s expected %h seen %h", name, exp, got); end end

    always #10 i_sys_clk = ~i_sys_clk;
    // one-cycle pulses are counted mid-cycle, where they are settled
    always @(negedge i_sys_clk) begin
        if (o_wakeup === 1'b1) n_wake <= n_wake + 1;
        if (o_wd_refresh === 1'b1) n_wd <= n_wd + 1;
        if (o_reset_req === 1'b1) n_rst <= n_rst + 1;
    end

    sbc_mode_cmd i_sbc_mode_cmd (.i_sys_clk(i_sys_clk), .i_rst(i_rst), .i_spi(spi), .o_spi_miso(o_spi_miso),
        .o_spi_miso_oe(o_spi_miso_oe), .i_rnd_guard_sel(i_rnd_guard_sel), .i_wake_pending(i_wake_pending),
        .i_safe_set(i_safe_set), .i_debug_strap(i_debug_strap), .o_mode(o_mode), .o_lp_cfg(o_lp_cfg),
        .o_debug(o_debug), .o_safe_on(o_safe_on), .o_wd_refresh(o_wd_refresh), .o_reset_req(o_reset_req),
        .o_wakeup(o_wakeup));
    sbc_spi_master i_sbc_spi_master (.i_sys_clk(i_sys_clk), .o_spi(spi), .i_spi_miso(miso_line));

    task automatic send(input logic [15:0] cmd);
        i_sbc_spi_master.xfer(cmd, rx);
    endtask : send

    task automatic do_reset(input logic guard);
        i_rnd_guard_sel = guard;
        i_rst = 1'b1;
        repeat (8) @(negedge i_sys_clk);
        i_rst = 1'b0;
        repeat (2) @(negedge i_sys_clk);
    endtask : do_reset

    function automatic logic [5:0] lp_exp(input logic [4:0] s);
        return s[4] ? {2'b01, s[3:0]} : {2'b10, s[1:0], 2'b00};
    endfunction : lp_exp

    task automatic finish_test();
        $display("checks %0d mismatches %0d", n_checks, mismatches);
        if (mismatches == 0 && n_checks > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : finish_test

    // watchdog: about 59 frames of 3 us each, with wide margin
    initial begin
        #1000000;
        mismatches++;
        finish_test();
    end

    initial begin
        do_reset(1'b0);
        `CHECK("mode", MODE_INIT, o_mode)
        `CHECK("debug", 1'b1, o_debug)
        i_safe_set = 1'b1;
        @(negedge i_sys_clk);
        i_safe_set = 1'b0;
        send(16'hDD80);
        `CHECK("keep debug", 1'b1, o_debug)
        `CHECK("safe off", 1'b0, o_safe_on)
        i_safe_set = 1'b1;
        @(negedge i_sys_clk);
        i_safe_set = 1'b0;
        send(16'hDD00);
        `CHECK("status", 16'h0003, rx)
        `CHECK("leave debug", 1'b0, o_debug)
        `CHECK("safe kept", 1'b1, o_safe_on)
        send(16'h1D80);
        `CHECK("status two", 16'h0003, rx)
        `CHECK("code read safe off", 1'b0, o_safe_on)
        send(CMD_WD_REFRESH);
        `CHECK("code frame", 13'h0000, rx[15:3])
        `CHECK("normal", MODE_NORMAL, o_mode)
        `CHECK("refresh", 1, n_wd)
        $display("test status done");
        // every low power code, woken by a pending flag
        for (int s = 12; s < 32; s++) begin
            send({8'h5C, 5'(s), 3'b000});
            `CHECK("lp mode", 5'(s), o_mode)
            `CHECK("lp cfg", lp_exp(5'(s)), o_lp_cfg)
            i_wake_pending = 1'b1;
            repeat (2) @(negedge i_sys_clk);
            i_wake_pending = 1'b0;
            `CHECK("woken", MODE_NORMAL_REQ, o_mode)
            send(CMD_WD_REFRESH);
            `CHECK("back normal", MODE_NORMAL, o_mode)
        end
        i_wake_pending = 1'b1;
        send(16'h5C60);
        i_wake_pending = 1'b0;
        `CHECK("wake at once", 21, n_wake)
        send(CMD_WD_REFRESH);
        send(16'h5C88);
        `CHECK("lp on", 5'h11, o_mode)
        send(16'h5C10);
        `CHECK("spi wake", MODE_NORMAL_REQ, o_mode)
        `CHECK("spi wake pulse", 22, n_wake)
        send(16'h5B80);
        `CHECK("flash", MODE_FLASH, o_mode)
        send(16'h5B00);
        `CHECK("reset", MODE_INIT, o_mode)
        `CHECK("reset pulse", 1, n_rst)
        $display("test modes done");
        // guarded entry; guard choice must freeze when leaving init
        do_reset(1'b1);
        send(CMD_WD_REFRESH);
        i_rnd_guard_sel = 1'b0;
        foreach (clr[i]) send(clr[i]);
        send(16'h1D00);
        `CHECK("code read leaves debug", 1'b0, o_debug)
        send(CMD_WD_REFRESH);
        `CHECK("read mode", MODE_NORMAL, rx[7:3])
        code = rx[2:0];
        send({8'h5C, 5'h0C, code});
        `CHECK("bad code", MODE_NORMAL, o_mode)
        send({8'h5C, 5'h0C, ~code});
        `CHECK("good code", 5'h0C, o_mode)
        $display("test guard done");
        finish_test();
    end
endmodule : testbench
